//--- core/trpc_cfg.svh
// timing and layout constants for the tape read parity checker
`ifndef TRPC_CFG_SVH
`define TRPC_CFG_SVH
`define TRPC_CLK_NS           25
`define TRPC_TEN_CLK_PERIODS  10
`define TRPC_EOD_HALF_PERIODS 5
`define TRPC_DISP_MS          250
`define TRPC_DISP_CYC         ((`TRPC_DISP_MS * 1000000) / `TRPC_CLK_NS)
`define TRPC_STOP_US          1
`define TRPC_STOP_CYC         ((`TRPC_STOP_US * 1000) / `TRPC_CLK_NS)
`define TRPC_TRACKS           9
`define TRPC_APB_CTRL         12'h000
`define TRPC_APB_STAT         12'h004
`define TRPC_CTRL_W           7
`endif

//--- core/trpc_pkg.sv
// types for the tape read parity checker
package trpc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_DATA  = 3'b001,
		ST_EOD   = 3'b010,
		ST_CHECK = 3'b011,
		ST_DISP  = 3'b100,
		ST_HALT  = 3'b101
	} trpc_state_t;
	typedef struct packed {
		logic       cyclic;
		logic       ram;
		logic       hi_range;
		logic       halt_on_error;
		logic       seven_track;
		logic       odd;
		logic       block;
	} trpc_ctrl_t;
	typedef struct packed {
		logic       fwd;
		logic       rev;
		logic       raw;
	} trpc_req_t;
endpackage

//--- core/trpc_top.sv
// tape read parity checker: vertical and longitudinal checks plus block motion control
`timescale 1ns/1ps
`include "trpc_cfg.svh"

module trpc_top (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire logic                   clk_en,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [8:0]             read_char,
	input  wire logic                   read_strobe,
	input  wire logic                   write_window_gate,
	output logic                        lateral_parity_lamp,
	output logic                        vpe_monitor,
	output logic      [8:0]             long_err_lamp,
	output logic                        ten_clock_gate,
	output logic                        reverse_motion_request,
	output logic                        forward_motion_request,
	output logic                        read_after_write_request
);
	// ========================================
	// registers
	trpc_pkg::trpc_ctrl_t  ctrl_r;
	trpc_pkg::trpc_state_t state_r;
	logic                  apb_hit;
	logic                  halt_prev_r;

	// access phase taken once; pready follows one cycle later from a flop
	assign apb_hit = psel && penable && !pready;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_r  <= '0;
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= apb_hit;
			pslverr <= 1'b0;
			// the write lands on the edge that completes the access, not before
			if (psel && penable && pready && pwrite && paddr == `TRPC_APB_CTRL)
				ctrl_r <= pwdata[`TRPC_CTRL_W-1:0];
			if (apb_hit) begin
				prdata <= 32'h0;
				if (paddr == `TRPC_APB_CTRL) begin
					if (!pwrite)
						prdata <= {25'h0, ctrl_r};
				end else if (paddr == `TRPC_APB_STAT) begin
					if (!pwrite)
						prdata <= {16'h0, 1'b0, state_r, long_err_lamp,
							lateral_parity_lamp, ten_clock_gate, 1'b0};
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// ========================================
	// link synchronisers, three stages, agree on stages two and three
	logic [2:0] stb_s;
	logic [2:0] wwg_s;
	logic [8:0] ch_s1, ch_s2, ch_s3, ch_q;
	logic       stb_q, wwg_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stb_s <= 3'h0;
			wwg_s <= 3'h0;
			ch_s1 <= 9'h0;
			ch_s2 <= 9'h0;
			ch_s3 <= 9'h0;
			ch_q  <= 9'h0;
			stb_q <= 1'b0;
			wwg_q <= 1'b0;
		end else if (clk_en) begin
			stb_s <= {stb_s[1:0], read_strobe};
			wwg_s <= {wwg_s[1:0], write_window_gate};
			ch_s1 <= read_char;
			ch_s2 <= ch_s1;
			ch_s3 <= ch_s2;
			if (ch_s2 == ch_s3)
				ch_q <= ch_s3;
			if (stb_s[1] == stb_s[2])
				stb_q <= stb_s[2];
			if (wwg_s[1] == wwg_s[2])
				wwg_q <= wwg_s[2];
		end
	end
	logic stb_rise, stb_prev, wwg_fall, wwg_prev;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stb_prev <= 1'b0;
			wwg_prev <= 1'b0;
		end else if (clk_en) begin
			stb_prev <= stb_q;
			wwg_prev <= wwg_q;
		end
	end
	assign stb_rise = stb_q && !stb_prev;
	assign wwg_fall = !wwg_q && wwg_prev;

	// ========================================
	// strobe period measurement, gives the window length
	// the window tracks tape speed so 800 bpi at 12.5 ips yields 1000 us
	logic [19:0] per_cnt_r, period_r;
	logic [23:0] win_cnt_r;
	logic [23:0] win_len;
	logic [20:0] eod_len;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			per_cnt_r <= 20'h0;
			period_r  <= 20'h0;
		end else if (clk_en) begin
			if (stb_rise) begin
				period_r  <= per_cnt_r;
				per_cnt_r <= 20'h1;
			end else if (per_cnt_r != 20'hfffff) begin
				per_cnt_r <= per_cnt_r + 20'h1;
			end
		end
	end
	// range select only limits which periods are plausible; hi range clamps long ones
	logic [19:0] per_used;
	assign per_used = (ctrl_r.hi_range && period_r[19:18] != 2'h0) ? 20'h3ffff : period_r;
	assign win_len = 24'(per_used) * 24'(`TRPC_TEN_CLK_PERIODS);
	assign eod_len = 21'((21'(per_used) * 21'(`TRPC_EOD_HALF_PERIODS)) >> 1);

	// ========================================
	// vertical parity, seven track masks tracks 0 and 1 (bits 0,1; bit 8 is P)
	logic [8:0] ch_mask;
	logic       vpe;
	assign ch_mask = ctrl_r.seven_track ? (ch_q & 9'h1fc) : ch_q;
	assign vpe = (^ch_mask) == ctrl_r.odd ? 1'b0 : 1'b1;

	// ========================================
	// sequencer
	logic [23:0] tmr_r;
	logic [8:0]  lxor_r;
	logic        any_err;
	logic        dir_rev_r;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r   <= trpc_pkg::ST_IDLE;
			tmr_r     <= 24'h0;
			lxor_r    <= 9'h0;
			win_cnt_r <= 24'h0;
			dir_rev_r <= 1'b0;
		end else if (clk_en) begin
			unique case (state_r)
				trpc_pkg::ST_IDLE: begin
					lxor_r <= 9'h0;
					if (ctrl_r.block)
						state_r <= trpc_pkg::ST_DATA;
				end
				trpc_pkg::ST_DATA: begin
					if (stb_rise)
						lxor_r <= lxor_r ^ ch_mask;
					if (!ctrl_r.block)
						state_r <= trpc_pkg::ST_IDLE;
					else if (wwg_fall) begin
						tmr_r   <= 24'(eod_len);
						state_r <= trpc_pkg::ST_EOD;
					end
				end
				trpc_pkg::ST_EOD: begin
					if (stb_rise)
						lxor_r <= lxor_r ^ ch_mask;
					if (tmr_r == 24'h0) begin
						// the zero count is a window cycle too
						win_cnt_r <= win_len - 24'(win_len != 24'h0);
						state_r   <= trpc_pkg::ST_CHECK;
					end else
						tmr_r <= tmr_r - 24'h1;
				end
				trpc_pkg::ST_CHECK: begin
					if (stb_rise)
						lxor_r <= lxor_r ^ ch_mask;
					if (win_cnt_r == 24'h0) begin
						tmr_r   <= 24'(`TRPC_DISP_CYC);
						state_r <= trpc_pkg::ST_DISP;
					end else
						win_cnt_r <= win_cnt_r - 24'h1;
				end
				trpc_pkg::ST_DISP: begin
					if (tmr_r == 24'h0) begin
						if (ctrl_r.halt_on_error && any_err)
							state_r <= trpc_pkg::ST_HALT;
						else begin
							lxor_r    <= 9'h0;
							dir_rev_r <= ctrl_r.cyclic ? !dir_rev_r : 1'b0;
							state_r   <= trpc_pkg::ST_DATA;
						end
					end else
						tmr_r <= tmr_r - 24'h1;
				end
				trpc_pkg::ST_HALT: begin
					if (ctrl_r.cyclic || !ctrl_r.block) begin
						lxor_r    <= 9'h0;
						dir_rev_r <= !dir_rev_r;
						state_r   <= ctrl_r.block ? trpc_pkg::ST_DATA : trpc_pkg::ST_IDLE;
					end
				end
				default: state_r <= trpc_pkg::ST_IDLE;
			endcase
		end
	end

	// ========================================
	// lamps; block-start clear and set-wins ordering
	logic blk_start;
	assign blk_start = (state_r == trpc_pkg::ST_DISP && tmr_r == 24'h0
		&& !(ctrl_r.halt_on_error && any_err)) || state_r == trpc_pkg::ST_IDLE;
	assign any_err = lateral_parity_lamp || (long_err_lamp != 9'h0);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lateral_parity_lamp <= 1'b0;
			vpe_monitor         <= 1'b0;
			long_err_lamp       <= 9'h0;
			halt_prev_r         <= 1'b0;
		end else if (clk_en) begin
			halt_prev_r <= ctrl_r.halt_on_error;
			vpe_monitor <= stb_rise && vpe;
			// the first block after motion starts may flag spuriously; left to the operator
			if (stb_rise && vpe && state_r != trpc_pkg::ST_CHECK)
				lateral_parity_lamp <= 1'b1;
			else if ((halt_prev_r != ctrl_r.halt_on_error) || (ctrl_r.block && blk_start))
				lateral_parity_lamp <= 1'b0;
			if (state_r == trpc_pkg::ST_CHECK && win_cnt_r == 24'h0)
				long_err_lamp <= lxor_r;
			else if (ctrl_r.block && blk_start)
				long_err_lamp <= 9'h0;
		end
	end

	// ========================================
	// motion requests and gates
	logic moving;
	assign moving = ctrl_r.block && (state_r == trpc_pkg::ST_DATA
		|| state_r == trpc_pkg::ST_EOD || state_r == trpc_pkg::ST_CHECK);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			forward_motion_request   <= 1'b0;
			reverse_motion_request   <= 1'b0;
			read_after_write_request <= 1'b0;
			ten_clock_gate           <= 1'b0;
		end else if (clk_en) begin
			forward_motion_request   <= moving && !dir_rev_r;
			reverse_motion_request   <= moving && dir_rev_r;
			read_after_write_request <= ctrl_r.block && ctrl_r.ram
				&& state_r == trpc_pkg::ST_DISP;
			ten_clock_gate           <= state_r == trpc_pkg::ST_CHECK;
		end
	end
	// momentary stop under normal policy is the display pause itself

	// ========================================
	// checks
	chk_cont_no_motion: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ctrl_r.block |=> ##1 !(forward_motion_request || reverse_motion_request))
		else $error("motion request in continuous mode");
	chk_halt_no_motion: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_r == trpc_pkg::ST_HALT && $past(state_r == trpc_pkg::ST_HALT) && clk_en
		|=> !forward_motion_request && !reverse_motion_request)
		else $error("motion request while halted");
	chk_vpe_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && stb_rise && vpe |=> vpe_monitor)
		else $error("vertical error not pulsed");
	chk_lat_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && stb_rise && vpe && state_r != trpc_pkg::ST_CHECK |=> lateral_parity_lamp)
		else $error("lateral lamp not set");
	chk_gate_check: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && state_r == trpc_pkg::ST_CHECK |=> ten_clock_gate)
		else $error("check gate not shown");
	chk_mask_seven: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ctrl_r.seven_track |-> ch_mask[1:0] == 2'h0)
		else $error("seven track bits not masked");
	sequence s_win_end;
		clk_en && state_r == trpc_pkg::ST_CHECK && win_cnt_r == 24'h0;
	endsequence
	chk_long_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_win_end |=> long_err_lamp == $past(lxor_r))
		else $error("longitudinal lamps wrong");
	chk_disp_after: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_win_end |=> state_r == trpc_pkg::ST_DISP ##1 !forward_motion_request)
		else $error("display not entered");
endmodule // trpc_top

//--- verification/trpc_tape_model.sv
// model of the tape read assembly and the write window gate
`timescale 1ns/1ps
module trpc_tape_model (
	input  wire logic       ref_clk,
	output logic      [8:0] read_char,
	output logic            read_strobe,
	output logic            write_window_gate
);
	// ==========================================================
	// link side
	// tape runs on its own here, whatever the requests say
	initial begin
		read_char = 9'h000;
		read_strobe = 1'b0;
		write_window_gate = 1'b0;
	end
	// one 200 ns period of eight clocks, called just after a clock edge; data
	// settles two clocks before the strobe and is inverted late in the period
	// so that a late sample never sees a stale copy
	task automatic send_char(input logic [8:0] c);
		read_char <= c;
		repeat (2) @(posedge ref_clk);
		read_strobe <= 1'b1;
		repeat (4) @(posedge ref_clk);
		read_strobe <= 1'b0;
		@(posedge ref_clk);
		read_char <= ~c;
		@(posedge ref_clk);
	endtask
	task automatic open_block();
		write_window_gate <= 1'b1;
	endtask
	// the check character trails the data gate by seven periods
	task automatic end_block(input logic [8:0] check_char);
		write_window_gate <= 1'b0;
		repeat (56) @(posedge ref_clk);
		send_char(check_char);
	endtask
endmodule // trpc_tape_model

//--- verification/trpc_top_tb.sv
// self-checking bench for the tape read parity checker
`timescale 1ns/1ps
module trpc_top_tb;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, lateral_parity_lamp, vpe_monitor, ten_clock_gate;
	logic [8:0]  read_char, long_err_lamp;
	logic        read_strobe, write_window_gate;
	logic        reverse_motion_request, forward_motion_request, read_after_write_request;
	logic [31:0] seed = 32'h3580b0cb;
	int          fails = 0;
	int          num_checks = 0;
	int          vpe_cnt = 0;

	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (vpe_monitor === 1'b1) vpe_cnt++;

	trpc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .read_char(read_char),
		.read_strobe(read_strobe), .write_window_gate(write_window_gate),
		.lateral_parity_lamp(lateral_parity_lamp), .vpe_monitor(vpe_monitor),
		.long_err_lamp(long_err_lamp), .ten_clock_gate(ten_clock_gate),
		.reverse_motion_request(reverse_motion_request),
		.forward_motion_request(forward_motion_request),
		.read_after_write_request(read_after_write_request));
	trpc_tape_model tape_u (.ref_clk(ref_clk), .read_char(read_char),
		.read_strobe(read_strobe), .write_window_gate(write_window_gate));

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// seven-track drops tracks 0 and 1 from the sum
	function automatic logic par_err(input logic [8:0] c, input logic odd, input logic sev);
		return (^(c & (sev ? 9'h1fc : 9'h1ff))) ^ odd;
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			finish_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	initial begin
		#2000000;
		fails++;
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] q;
		logic        e;
		logic [8:0]  c;
		logic [8:0]  acc;
		int          errs, base, n, w;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check("reset outputs", {lateral_parity_lamp, long_err_lamp, forward_motion_request,
			reverse_motion_request, read_after_write_request}, 32'h0);
		apb(1'b0, 12'h008, 32'h0, q, e);
		check("unmapped error", e, 32'h1);
		// continuous mode, every parity sense and track count; halt bit toggles
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h000, {28'h0, m[0], m[1], m[0], 1'b0}, q, e);
			repeat (2) @(posedge ref_clk);
			check("lamp cleared", lateral_parity_lamp, 32'h0);
			base = vpe_cnt;
			errs = 0;
			for (int i = 0; i < 12; i++) begin
				c = (i == 0) ? 9'h1ff : 9'(rnd());
				errs += par_err(c, m[0], m[1]);
				tape_u.send_char(c);
			end
			repeat (8) @(posedge ref_clk);
			check("error pulses", vpe_cnt - base, errs);
			check("lateral lamp", lateral_parity_lamp, errs > 0);
			check("no requests", {forward_motion_request, reverse_motion_request,
				read_after_write_request}, 32'h0);
		end
		// block read-after-write, nine-track even, bad check character on P and track 2
		apb(1'b1, 12'h000, 32'h21, q, e);
		acc = 9'h000;
		tape_u.open_block();
		for (int i = 0; i < 10; i++) begin
			c[7:0] = 8'(rnd());
			c[8] = ^c[7:0];
			acc ^= c;
			tape_u.send_char(c);
		end
		check("motion forward", {forward_motion_request, reverse_motion_request}, 32'h2);
		fork
			tape_u.end_block(acc ^ 9'h104);
			begin
				n = 0;
				while (ten_clock_gate !== 1'b1 && n < 200) begin
					@(posedge ref_clk);
					n++;
				end
				w = 0;
				while (ten_clock_gate === 1'b1 && w < 200) begin
					@(posedge ref_clk);
					w++;
				end
			end
		join
		check("window start", n >= 16 && n <= 32, 32'h1);
		check("window width", w >= 72 && w <= 88, 32'h1);
		repeat (4) @(posedge ref_clk);
		check("track lamps", long_err_lamp, 32'h104);
		check("forward dropped", forward_motion_request, 32'h0);
		check("write inhibit", read_after_write_request, 32'h1);
		apb(1'b0, 12'h004, 32'h0, q, e);
		check("status lamps", q[11:3], 32'h104);
		finish_test();
	end
endmodule // trpc_top_tb
